// ### logic/sbm_write_mask.sv
`timescale 1ns/10ps
module sbm_write_mask
	import sbm_pkg::*;
(
	// System
	input  wire logic                  CLK,
	input  wire logic                  RST,
	// Device pins, sampled from outside the clock domain
	input  wire logic                  K,
	input  wire logic                  K_N,
	input  wire logic                  WRITE_PORT_SELECT_N,
	input  wire logic [SBM_ADDR_W-1:0] ADDR,
	input  wire logic [SBM_DATA_W-1:0] DATA,
	input  wire logic                  LANE_WRITE_SEL_0_N,
	input  wire logic                  LANE_WRITE_SEL_1_N,
	input  wire logic                  LANE_WRITE_SEL_2_N,
	input  wire logic                  LANE_WRITE_SEL_3_N,
	input  wire logic [1:0]            ORG_SEL,
	// Array side
	input  wire logic                  ARRAY_HOLD,
	input  wire logic [SBM_IDX_W-1:0]  RD_ADDR,
	output logic      [SBM_DATA_W-1:0] RD_DATA,
	// Status
	output logic                       WRITE_BUSY,
	output logic                       BEAT_LOST
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [SBM_SYNC_W-1:0] pin_raw;
	logic [SBM_SYNC_W-1:0] sync1;
	logic [SBM_SYNC_W-1:0] sync2;
	logic [SBM_SYNC_W-1:0] sync3;
	logic                  k_level;
	logic                  kn_level;
	logic                  k_rise;
	logic                  kn_rise;
	logic                  port_sel_n;
	logic [SBM_ADDR_W-1:0] addr_s;
	logic [SBM_DATA_W-1:0] data_s;
	logic [SBM_LANES-1:0]  lane_n;
	sbm_org_e              org;
	logic                  low_nibble_write_sel;
	logic                  high_nibble_write_sel;

	assign pin_raw = {K, K_N, WRITE_PORT_SELECT_N, ORG_SEL[1], ORG_SEL[0], ADDR, DATA,
	                  LANE_WRITE_SEL_3_N, LANE_WRITE_SEL_2_N,
	                  LANE_WRITE_SEL_1_N, LANE_WRITE_SEL_0_N, 1'b0};

	// Idle pin levels: K low, K_N and port select high
	localparam logic [SBM_SYNC_W-1:0] SYNC_IDLE = {3'h3, {(SBM_SYNC_W-3){1'b0}}};

	// Three stages; stage one feeds stage two only
	// Reset to the idle levels, so the high K_N pin gives no false rise
	always_ff @(posedge CLK) begin
		if (RST) begin
			sync1 <= SYNC_IDLE;
			sync2 <= SYNC_IDLE;
			sync3 <= SYNC_IDLE;
		end else begin
			sync1 <= pin_raw;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// Bus fields taken from the third stage, aligned with the edges
	assign lane_n = sync3[SBM_LANES:1];
	assign data_s = sync3[SBM_LANES+SBM_DATA_W:SBM_LANES+1];
	assign addr_s = sync3[SBM_LANES+SBM_DATA_W+SBM_ADDR_W:SBM_LANES+SBM_DATA_W+1];
	assign org    = sbm_org_e'(sync3[SBM_SYNC_W-4:SBM_SYNC_W-5]);
	assign port_sel_n = sync3[SBM_SYNC_W-3];
	// Nibble selects of the x8 organisation share lanes 0 and 1
	assign low_nibble_write_sel  = lane_n[0];
	assign high_nibble_write_sel = lane_n[1];

	// Clock levels move only when stages two and three agree
	always_ff @(posedge CLK) begin
		if (RST) begin
			k_level  <= 1'b0;
			kn_level <= 1'b1; // Complement idles high
		end else begin
			if (sync2[SBM_SYNC_W-1] == sync3[SBM_SYNC_W-1]) begin
				k_level <= sync3[SBM_SYNC_W-1];
			end
			if (sync2[SBM_SYNC_W-2] == sync3[SBM_SYNC_W-2]) begin
				kn_level <= sync3[SBM_SYNC_W-2];
			end
		end
	end

	assign k_rise  = sync2[SBM_SYNC_W-1] & sync3[SBM_SYNC_W-1] & ~k_level;
	assign kn_rise = sync2[SBM_SYNC_W-2] & sync3[SBM_SYNC_W-2] & ~kn_level;

	// ----------------------------------------------------------------
	// Per-bit write enables from the lane selects
	// ----------------------------------------------------------------
	logic [SBM_DATA_W-1:0] bit_en;

	// Lane width and bus width follow the organisation; bits past the width never write
	always_comb begin
		bit_en = '0;
		for (int i = 0; i < SBM_DATA_W; i++) begin
			case (org)
				SBM_ORG_X8: begin
					if (i < SBM_X8_W) begin
						bit_en[i] = (i < SBM_NIBBLE_W) ? ~low_nibble_write_sel
						                               : ~high_nibble_write_sel;
					end
				end
				SBM_ORG_X9: begin
					if (i < SBM_X9_W) begin
						bit_en[i] = ~lane_n[0];
					end
				end
				SBM_ORG_X18: begin
					if (i < SBM_X18_W) begin
						bit_en[i] = ~lane_n[i / SBM_BYTE_W];
					end
				end
				SBM_ORG_X36: begin
					bit_en[i] = ~lane_n[i / SBM_BYTE_W];
				end
				default: begin
					bit_en[i] = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Write burst sequencing
	// ----------------------------------------------------------------
	logic                  prev_start;
	logic                  pend;
	logic [SBM_ADDR_W-1:0] pend_addr;
	logic                  active;
	logic [SBM_ADDR_W-1:0] cur_addr;
	logic [SBM_BEAT_W-1:0] next_beat;
	logic                  start;
	logic                  beat_take;
	logic [SBM_BEAT_W-1:0] beat_no;
	logic [SBM_ADDR_W-1:0] beat_addr;

	// A start right after an accepted one is dropped with its data
	assign start = k_rise & ~port_sel_n & ~prev_start;

	// Address side, latched on the clock rise only
	always_ff @(posedge CLK) begin
		if (RST) begin
			prev_start <= 1'b0;
			pend       <= 1'b0;
			pend_addr  <= '0;
		end else if (k_rise) begin
			prev_start <= start;
			pend       <= start;
			if (start) begin
				pend_addr <= addr_s;
			end
		end
	end

	// Beat order: K t+1, K_N t+1, K t+2, K_N t+2
	always_comb begin
		beat_take = 1'b0;
		beat_no   = SBM_BEAT0;
		beat_addr = cur_addr;
		if (k_rise && pend) begin
			beat_take = 1'b1;
			beat_addr = pend_addr;
		end else if (k_rise && active && next_beat == SBM_BEAT2) begin
			beat_take = 1'b1;
			beat_no   = SBM_BEAT2;
		end else if (kn_rise && active &&
		             (next_beat == SBM_BEAT1 || next_beat == SBM_BEAT3)) begin
			beat_take = 1'b1;
			beat_no   = next_beat;
		end
	end

	// Burst progress; beats outside a started burst never reach the array
	always_ff @(posedge CLK) begin
		if (RST) begin
			active    <= 1'b0;
			cur_addr  <= '0;
			next_beat <= SBM_BEAT0;
		end else if (beat_take) begin
			if (beat_no == SBM_BEAT0) begin
				cur_addr <= pend_addr;
			end
			next_beat <= beat_no + 1'b1;
			active    <= (beat_no != SBM_BEAT3);
		end
	end

	assign WRITE_BUSY = active | pend;

	// ----------------------------------------------------------------
	// Beat FIFO
	// ----------------------------------------------------------------
	sbm_beat_if #(.W(SBM_ENTRY_W)) beat_bus ();

	// Each beat carries its own mask, sampled at its own edge
	assign beat_bus.in_valid  = beat_take & (|bit_en);
	assign beat_bus.in_data   = {beat_addr, beat_no, bit_en, data_s};
	assign beat_bus.out_ready = ~ARRAY_HOLD;

	sbm_fifo #(
		.WIDTH (SBM_ENTRY_W),
		.DEPTH (SBM_FIFO_DEPTH)
	) u_fifo (
		.CLK (CLK),
		.RST (RST),
		.bus (beat_bus.fifo)
	);

	// A full FIFO cannot stall pins that run free, so the loss is reported
	always_ff @(posedge CLK) begin
		if (RST) begin
			BEAT_LOST <= 1'b0;
		end else begin
			BEAT_LOST <= beat_bus.in_valid & ~beat_bus.in_ready;
		end
	end

	// ----------------------------------------------------------------
	// Storage array with bitwise merge
	// ----------------------------------------------------------------
	logic [SBM_DATA_W-1:0] array_q [SBM_WORDS];
	logic [SBM_IDX_W-1:0]  wr_idx;
	logic [SBM_DATA_W-1:0] wr_en;
	logic [SBM_DATA_W-1:0] wr_data;

	assign wr_data = beat_bus.out_data[SBM_DATA_W-1:0];
	assign wr_en   = beat_bus.out_data[2*SBM_DATA_W-1:SBM_DATA_W];
	assign wr_idx  = beat_bus.out_data[SBM_ENTRY_W-1:2*SBM_DATA_W];

	// Unselected bits keep their stored value
	always_ff @(posedge CLK) begin
		if (beat_bus.out_valid && !ARRAY_HOLD) begin
			array_q[wr_idx] <= (array_q[wr_idx] & ~wr_en) | (wr_data & wr_en);
		end
	end

	// Registered read-back
	always_ff @(posedge CLK) begin
		if (RST) begin
			RD_DATA <= '0;
		end else begin
			RD_DATA <= array_q[RD_ADDR];
		end
	end
endmodule : sbm_write_mask

// ### logic/sbm_pkg.sv
package sbm_pkg;
	// ----------------------------------------------------------------
	// Word organisations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SBM_ORG_X8,
		SBM_ORG_X9,
		SBM_ORG_X18,
		SBM_ORG_X36
	} sbm_org_e;

	// ----------------------------------------------------------------
	// Data path geometry
	// ----------------------------------------------------------------
	localparam int SBM_DATA_W    = 36;
	localparam int SBM_LANES     = 4;
	localparam int SBM_NIBBLE_W  = 4;
	localparam int SBM_BYTE_W    = 9;
	localparam int SBM_X8_W      = 8;
	localparam int SBM_X9_W      = 9;
	localparam int SBM_X18_W     = 18;
	localparam int SBM_X36_W     = 36;

	// ----------------------------------------------------------------
	// Burst and storage
	// ----------------------------------------------------------------
	localparam int SBM_ADDR_W    = 3;
	localparam int SBM_BEAT_W    = 2;
	localparam int SBM_IDX_W     = SBM_ADDR_W + SBM_BEAT_W;
	localparam int SBM_WORDS     = 1 << SBM_IDX_W;
	localparam int SBM_FIFO_DEPTH = 32;
	localparam int SBM_ENTRY_W   = SBM_IDX_W + 2 * SBM_DATA_W;
	localparam int SBM_SYNC_W    = 4 + SBM_ADDR_W + SBM_DATA_W + SBM_LANES + 2;

	localparam logic [SBM_BEAT_W-1:0] SBM_BEAT0 = 2'h0;
	localparam logic [SBM_BEAT_W-1:0] SBM_BEAT1 = 2'h1;
	localparam logic [SBM_BEAT_W-1:0] SBM_BEAT2 = 2'h2;
	localparam logic [SBM_BEAT_W-1:0] SBM_BEAT3 = 2'h3;
endpackage : sbm_pkg

// ### logic/sbm_beat_if.sv
`timescale 1ns/10ps
// Masked beats travelling from the capture logic through the FIFO
interface sbm_beat_if #(parameter int W = 8);
	logic         in_valid;
	logic         in_ready;
	logic [W-1:0] in_data;
	logic         out_valid;
	logic         out_ready;
	logic [W-1:0] out_data;

	modport fifo (input in_valid, in_data, out_ready,
	              output in_ready, out_valid, out_data);
	modport user (output in_valid, in_data, out_ready,
	              input in_ready, out_valid, out_data);
endinterface : sbm_beat_if

// ### logic/sbm_fifo.sv
`timescale 1ns/10ps
module sbm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic CLK,
	input wire logic RST,
	sbm_beat_if.fifo bus
);
	localparam int PW = $clog2(DEPTH);

	// ----------------------------------------------------------------
	// Storage and pointers
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;
	logic             push;
	logic             pop;

	// Honest flags straight from the occupancy count
	assign bus.in_ready  = (count != (PW+1)'(DEPTH));
	assign bus.out_valid = (count != '0);
	assign bus.out_data  = mem[rd_ptr];
	assign push = bus.in_valid & bus.in_ready;
	assign pop  = bus.out_valid & bus.out_ready;

	// Write side
	always_ff @(posedge CLK) begin
		if (push) begin
			mem[wr_ptr] <= bus.in_data;
		end
		if (RST) begin
			wr_ptr <= '0;
		end else if (push) begin
			wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
		end
	end

	// Read side
	always_ff @(posedge CLK) begin
		if (RST) begin
			rd_ptr <= '0;
		end else if (pop) begin
			rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
		end
	end

	// Occupancy
	always_ff @(posedge CLK) begin
		if (RST) begin
			count <= '0;
		end else if (push != pop) begin
			count <= push ? count + 1'b1 : count - 1'b1;
		end
	end
endmodule : sbm_fifo

// ### testbench/sbm_write_mask_asserts.sv
`timescale 1ns/10ps
module sbm_write_mask_asserts
	import sbm_pkg::*;
(
	// Clock and reset
	input wire logic                  CLK,
	input wire logic                  RST,
	// Watched pins
	input wire logic                  K,
	input wire logic                  K_N,
	input wire logic                  WRITE_PORT_SELECT_N,
	input wire logic                  ARRAY_HOLD,
	input wire logic [SBM_DATA_W-1:0] RD_DATA,
	input wire logic                  WRITE_BUSY,
	input wire logic                  BEAT_LOST
);
	logic [5:0] idle_cnt;

	// Cycles since the start pin was last low, saturating so it never wraps
	always_ff @(posedge CLK) begin
		if (RST || !WRITE_PORT_SELECT_N) begin
			idle_cnt <= 6'h00;
		end else if (idle_cnt != 6'h3F) begin
			idle_cnt <= idle_cnt + 6'h01;
		end
	end

	default clocking @(posedge CLK); endclocking
	default disable iff (RST);

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	rst_clear_a: assert property (disable iff (1'b0)
		RST |=> (RD_DATA == '0 && !BEAT_LOST && !WRITE_BUSY)) else $error("reset values wrong");
	lost_pulse_a: assert property (BEAT_LOST |=> !BEAT_LOST) else $error("loss pulse too long");
	lost_hold_a: assert property ((!ARRAY_HOLD) [*4] |-> !BEAT_LOST) else $error("loss no stall");
	busy_start_a: assert property ($rose(WRITE_BUSY) |-> $past(K && !WRITE_PORT_SELECT_N, 2))
		else $error("burst began without start");
	busy_len_a: assert property ($rose(WRITE_BUSY) |-> ##37 WRITE_BUSY ##[1:6] !WRITE_BUSY)
		else $error("burst length wrong");
	busy_end_a: assert property ($fell(WRITE_BUSY) |-> $past(K_N, 2))
		else $error("burst ended off complement rise");
	busy_gap_a: assert property ($fell(WRITE_BUSY) |-> (!WRITE_BUSY) [*4])
		else $error("burst restarted too soon");
	idle_busy_a: assert property (idle_cnt == 6'h3F |-> !WRITE_BUSY)
		else $error("busy without start");

	// Main scenarios reached
	cover property (BEAT_LOST);
	cover property ($fell(WRITE_BUSY));
	cover property (ARRAY_HOLD && WRITE_BUSY);
endmodule : sbm_write_mask_asserts

bind sbm_write_mask sbm_write_mask_asserts sbm_write_mask_asserts_i (.CLK(CLK), .RST(RST),
	.K(K), .K_N(K_N), .WRITE_PORT_SELECT_N(WRITE_PORT_SELECT_N), .ARRAY_HOLD(ARRAY_HOLD),
	.RD_DATA(RD_DATA), .WRITE_BUSY(WRITE_BUSY), .BEAT_LOST(BEAT_LOST));

// ### testbench/sbm_ctl_model.sv
`timescale 1ns/10ps
module sbm_ctl_model
	import sbm_pkg::*;
(
	// Input clock pair
	output logic                  k,
	output logic                  k_n,
	// Write port pins
	output logic                  port_sel_n,
	output logic [SBM_ADDR_W-1:0] addr,
	output logic [SBM_DATA_W-1:0] data,
	output logic [SBM_LANES-1:0]  lanes_n
);
	// Free running pair, 8 CLK a phase; edges 1 ns after a CLK rise, like the bench
	initial begin
		k = 1'b0;
		k_n = 1'b1;
		port_sel_n = 1'b1;
		addr = '0;
		data = '0;
		lanes_n = '1;
		#21;
		forever begin
			#320;
			k = ~k;
			k_n = ~k_n;
		end
	end

	// Pins change midway between rises, so they stand 4 CLK either side
	task automatic slot(input logic on_k);
		if (on_k) @(posedge k);
		else @(posedge k_n);
		#160;
	endtask : slot

	// One burst; dbl repeats the start on the rise right after it
	task automatic burst(input logic [SBM_ADDR_W-1:0] a, input logic [SBM_DATA_W-1:0] q,
		input logic [15:0] ln, input logic dbl);
		slot(1'b0);
		port_sel_n = 1'b0;
		addr = a;
		for (int b = 0; b < 4; b++) begin
			slot(b != 2); // Beats at K, K_N, K, K_N after the start
			data = q ^ {9{4'(b)}};
			lanes_n = ln[4*b +: 4]; // Fresh selects each beat
			port_sel_n = !(dbl && b == 0); // Illegal repeat start when asked
			addr = ~a;
		end
		slot(1'b0);
		// Released: inverse data, selects low that must not act
		data = ~data;
		lanes_n = '0;
	endtask : burst
endmodule : sbm_ctl_model

// ### testbench/sbm_write_mask_tb.sv
`timescale 1ns/10ps
module sbm_write_mask_tb
	import sbm_pkg::*;
;
	typedef struct {
		sbm_org_e              org;
		logic [SBM_ADDR_W-1:0] a;
		logic [SBM_DATA_W-1:0] q;
		logic [15:0]           ln;
	} sbm_row_s;
	logic                  clk, rst, hold, busy, lost, k, k_n, port_sel_n;
	logic [SBM_IDX_W-1:0]  rd_addr;
	logic [SBM_DATA_W-1:0] rd_data, data, d, wm;
	logic [SBM_ADDR_W-1:0] addr;
	logic [SBM_LANES-1:0]  lanes_n;
	sbm_org_e              org;
	int                    bad_count, check_count, lost_n;
	// Selects per beat {b3,b2,b1,b0}; an F beat writes nothing
	sbm_row_s rows [5] = '{'{SBM_ORG_X8, 3'h1, 36'h9A5C3E71B, 16'hFCDE},
		'{SBM_ORG_X9, 3'h2, 36'h3C96A5F0E, 16'hFEFE}, '{SBM_ORG_X18, 3'h3, 36'h5F0A3C9E7, 16'hEFCD},
		'{SBM_ORG_X36, 3'h4, 36'hC3A59E1B6, 16'h7BDE}, '{SBM_ORG_X36, 3'h6, 36'h6E1F0D2C8, 16'hAF50}};

	sbm_write_mask sbm_write_mask_i (.CLK(clk), .RST(rst), .K(k), .K_N(k_n),
		.WRITE_PORT_SELECT_N(port_sel_n), .ADDR(addr), .DATA(data),
		.LANE_WRITE_SEL_0_N(lanes_n[0]),
		.LANE_WRITE_SEL_1_N(lanes_n[1]), .LANE_WRITE_SEL_2_N(lanes_n[2]),
		.LANE_WRITE_SEL_3_N(lanes_n[3]), .ORG_SEL(org), .ARRAY_HOLD(hold), .RD_ADDR(rd_addr),
		.RD_DATA(rd_data), .WRITE_BUSY(busy), .BEAT_LOST(lost));
	sbm_ctl_model sbm_ctl_model_i (.k(k), .k_n(k_n), .port_sel_n(port_sel_n), .addr(addr),
		.data(data),
		.lanes_n(lanes_n));

	// Bits a beat may write for an organisation and its selects
	function automatic logic [SBM_DATA_W-1:0] lmask(sbm_org_e o, logic [3:0] n);
		case (o)
			SBM_ORG_X8: lmask = {28'h0, {4{~n[1]}}, {4{~n[0]}}};
			SBM_ORG_X9: lmask = {27'h0, {9{~n[0]}}};
			SBM_ORG_X18: lmask = {18'h0, {9{~n[1]}}, {9{~n[0]}}};
			default: lmask = {{9{~n[3]}}, {9{~n[2]}}, {9{~n[1]}}, {9{~n[0]}}};
		endcase
	endfunction : lmask

	function automatic logic [SBM_DATA_W-1:0] pat(int b);
		pat = {9{4'(b)}};
	endfunction : pat

	task automatic check(string what, logic [SBM_DATA_W-1:0] seen, logic [SBM_DATA_W-1:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic close_out();
		$display("Checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out

	// Bounded wait for the burst to end, then time for the queue to drain
	task automatic settle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 100) begin
			@(posedge clk);
			n++;
		end
		if (n == 100) begin
			bad_count++;
			close_out();
		end
		repeat (40) @(posedge clk);
		#1;
	endtask : settle

	// Word is read back one cycle after its index is presented
	task automatic rdchk(string what, logic [4:0] i, logic [35:0] exp, logic [35:0] m);
		@(posedge clk);
		#1;
		rd_addr = i;
		@(posedge clk);
		#1;
		check(what, rd_data & m, exp & m);
	endtask : rdchk

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Stall flag counted per cycle, read mid-cycle to stay clear of its launch edge
	always @(negedge clk) if (lost === 1'b1) lost_n++;

	initial begin
		#500000;
		bad_count++;
		close_out();
	end

	initial begin
		rst = 1'b1;
		hold = 1'b0;
		rd_addr = '0;
		org = SBM_ORG_X36;
		repeat (2) @(posedge clk);
		#1;
		check("reset rd_data", rd_data, '0);
		check("reset busy", 36'(busy), '0);
		check("reset lost", 36'(lost), '0);
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		// Full prewrite, then a masked burst, then every beat read back
		foreach (rows[i]) begin
			org = rows[i].org;
			wm = lmask(org, 4'h0);
			sbm_ctl_model_i.burst(rows[i].a, ~rows[i].q, 16'h0000, 1'b0);
			sbm_ctl_model_i.burst(rows[i].a, rows[i].q, rows[i].ln, 1'b0);
			settle();
			for (int b = 0; b < 4; b++) begin
				d = rows[i].q ^ pat(b);
				rdchk("row", {rows[i].a, 2'(b)}, d ^ ~lmask(org, rows[i].ln[4*b +: 4]), wm);
			end
		end
		// A second start on the next rise must leave its address alone
		org = SBM_ORG_X36;
		sbm_ctl_model_i.burst(3'h2, 36'hA5A5A5A5A, 16'h0000, 1'b0);
		sbm_ctl_model_i.burst(3'h5, 36'h0F1E2D3C4, 16'h0000, 1'b1);
		settle();
		for (int b = 0; b < 4; b++) begin
			rdchk("ignored start", {3'h2, 2'(b)}, 36'hA5A5A5A5A ^ pat(b), '1);
			rdchk("first start", {3'h5, 2'(b)}, 36'h0F1E2D3C4 ^ pat(b), '1);
		end
		// Stalled array: 32 beats queue, the ninth burst's four are dropped
		hold = 1'b1;
		lost_n = 0;
		for (int i = 0; i < 9; i++) begin
			sbm_ctl_model_i.burst(3'(i), 36'h123456789 + 36'(i), 16'h0000, 1'b0);
		end
		repeat (8) @(posedge clk);
		#1;
		check("lost beats", 36'(lost_n), 36'h4);
		hold = 1'b0;
		settle();
		rdchk("kept after full", 5'h00, 36'h123456789, '1);
		rdchk("last queued", 5'h1F, (36'h123456789 + 36'h7) ^ pat(3), '1);
		close_out();
	end
endmodule : sbm_write_mask_tb
